// ---- hdl/cmt_pkg.sv ----
// Purpose: shared constants for the CAN mailbox and timer unit
// Assumes: 32-bit Avalon-MM byte addressing, one word per register
// Notes:   mailbox registers repeat every 32 bytes from MB_BASE
package cmt_pkg;
	localparam int          NUM_MBOX     = 8;
	localparam int          ADDR_W       = 10;
	localparam int          ID_W         = 29;
	localparam int          STD_ID_W     = 11;
	localparam int          TIM_W        = 16;
	// ************************************************************
	// global register byte offsets
	// ************************************************************
	localparam logic [9:0]  MR_OFS       = 10'h000;
	localparam logic [9:0]  IMR_OFS      = 10'h004;
	localparam logic [9:0]  SR_OFS       = 10'h008;
	localparam logic [9:0]  TCR_OFS      = 10'h00C;
	localparam logic [9:0]  TIM_OFS      = 10'h010;
	localparam logic [9:0]  STP_OFS      = 10'h014;
	localparam logic [9:0]  MB_BASE      = 10'h200;
	// ************************************************************
	// per-mailbox register index (byte offset / 4 inside a mailbox)
	// ************************************************************
	localparam logic [2:0]  MB_MMR       = 3'h0;
	localparam logic [2:0]  MB_MAM       = 3'h1;
	localparam logic [2:0]  MB_MID       = 3'h2;
	localparam logic [2:0]  MB_FID       = 3'h3;
	localparam logic [2:0]  MB_MSR       = 3'h4;
	localparam logic [2:0]  MB_DL        = 3'h5;
	localparam logic [2:0]  MB_DH        = 3'h6;
	localparam logic [2:0]  MB_MCR       = 3'h7;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int          MR_EN        = 0;
	localparam int          MR_LPM       = 1;
	localparam int          MR_HOLD      = 2;
	localparam int          MR_STAMP_AT_FRAME_END      = 3;
	localparam int          MR_TTM       = 4;
	localparam int          SR_WRAP      = 0;
	localparam int          SR_STAMP     = 1;
	localparam int          SR_SLEEP     = 2;
	localparam int          TCR_TCLR     = 31;
	localparam int          MID_IDE      = 29;
	localparam int          MSR_RDY      = 23;
	localparam int          MSR_PEND     = 24;
	localparam int          MCR_ACK      = 23;
	localparam int          MMR_TYPE_LO  = 24;
	localparam int          MMR_PRIO_LO  = 16;
	// ************************************************************
	// object types and reset values
	// ************************************************************
	localparam logic [2:0]  OT_OFF       = 3'h0;
	localparam logic [2:0]  OT_RX        = 3'h1;
	localparam logic [2:0]  OT_RXOVR     = 3'h2;
	localparam logic [2:0]  OT_TX        = 3'h3;
	localparam logic [2:0]  OT_CONS      = 3'h4;
	localparam logic [2:0]  OT_PROD      = 3'h5;
	localparam logic [15:0] TIM_MAX      = 16'hFFFF;
	localparam logic [31:0] WORD_ZERO    = 32'h00000000;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_BUSY = 2'b10
	} cmt_txst_t;
endpackage

// ---- hdl/cmt_mailbox_unit.sv ----
// Purpose: eight CAN mailboxes with acceptance, arbitration and time unit
// Assumes: frame engine outside delivers decoded frames and bit ticks
// Notes:   bit timing, error handling and framing live in the engine
//
// What this block does
// [R1] eight mailboxes, each typed receive or transmit by its object-type field
// [R2] extended-id select picks 29-bit or 11-bit identifier handling
// [R3] masked received id compared with mailbox id; accepted id stored back
// [R4] variable (mask-zero) id bits gathered into readable family id
// [R5] family bits packed from bit zero upward, order kept, zeros above
// [R6] lowest-numbered available matching receive mailbox takes the data
// [R7] receive-only locks until acknowledged; overwrite mode takes every newer match
// [R8] consumer sends remote frame per request, keeps first matching answer
// [R9] software chains same-id receive mailboxes, last may overwrite
// [R10] highest-priority pending transmit mailbox is sent first
// [R11] producer answers matching remote frame with its data automatically
// [R12] mailboxes may share ids and ids may be rewritten anytime
// [R13] 16-bit timer counts bit ticks while controller enabled
// [R14] timer cleared by reset, low power, re-enable, time-triggered last-mailbox ready
// [R15] timer-clear command resets timer; timer value always readable
// [R16] wrap from FFFF to 0000 sets wrap flag; status read clears it
// [R17] interrupt asserted while wrap flag set and its mask enabled
// [R18] hold enable stops timer at FFFF, flags wrap, until auto clear
// [R19] timer copied to stamp register at frame end or start per select
// [R20] status read clears stamp flag; masked flag drives interrupt
// [R21] time-triggered mode starts transfers when timer meets mailbox trigger
// [R22] frames up to 108 standard and 128 extended bits handled
// [R23] remote, error, overload frames handled by hardware, not software
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/10ps
module cmt_mailbox_unit #(
	parameter int NMB = cmt_pkg::NUM_MBOX
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [9:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic        bitTick,
	input  wire logic        sofPulse,
	input  wire logic        eofPulse,
	input  wire logic        sleepState,
	input  wire logic        rxValid,
	input  wire logic        rxExt,
	input  wire logic        rxRemote,
	input  wire logic [28:0] rxId,
	input  wire logic [3:0]  rxLen,
	input  wire logic [63:0] rxData,
	output logic             txReq,
	output logic             txExt,
	output logic             txRemote,
	output logic      [28:0] txId,
	output logic      [3:0]  txLen,
	output logic      [63:0] txData,
	input  wire logic        txDone,
	output logic             irq
);
	// ************************************************************
	// functions
	// ************************************************************
	function automatic logic [28:0] idRange(input logic ext);
		idRange = ext ? {29{1'b1}} : {{11{1'b1}}, 18'h00000};
	endfunction

	function automatic logic idMatch(input logic [31:0] mid, input logic [31:0] mam,
		input logic [28:0] id, input logic ext);
		idMatch = (mid[cmt_pkg::MID_IDE] == ext) &&
			(((id ^ mid[28:0]) & mam[28:0] & idRange(ext)) == 29'h00000000); // [R2] [R3]
	endfunction

	function automatic logic [31:0] packFamily(input logic [28:0] id, input logic [28:0] mam,
		input logic ext);
		logic [31:0] acc;
		logic [5:0]  pos;
		logic [28:0] rng;
		acc = 32'h00000000;
		pos = 6'h00;
		rng = idRange(ext);
		for (int b = 0; b < cmt_pkg::ID_W; b++) begin
			if (rng[b] && !mam[b]) begin
				acc[pos[4:0]] = id[b]; // [R4] [R5]
				pos = pos + 6'h01;
			end
		end
		packFamily = acc;
	endfunction

	function automatic logic [2:0] lowestSet(input logic [7:0] v);
		lowestSet = 3'h0;
		for (int k = 7; k >= 0; k--) begin
			if (v[k]) lowestSet = 3'(k);
		end
	endfunction

	// ************************************************************
	// storage
	// ************************************************************
	logic [31:0]              mmrQ [NMB];
	logic [31:0]              mamQ [NMB];
	logic [31:0]              midQ [NMB];
	logic [31:0]              fidQ [NMB];
	logic [31:0]              dlQ  [NMB];
	logic [31:0]              dhQ  [NMB];
	logic [3:0]               lenQ [NMB];
	logic [NMB-1:0]           rdyQ, rdyD, pendQ, pendD, waitAnsQ, waitAnsD;
	logic [4:0]               mrQ;
	logic [1:0]               imrQ;
	logic                     wrapQ, stampQ, enPrevQ, lastRdyPrevQ;
	logic [15:0]              timQ, timD, stpQ;
	logic                     waitQ;
	logic [2:0]               txIdxQ;
	cmt_pkg::cmt_txst_t       txStQ;

	// ************************************************************
	// bus decode
	// ************************************************************
	wire       busReq   = read | write;
	wire       busDone  = busReq & ~waitQ;
	wire       wrEn     = write & busDone;
	wire       rdEn     = read & busDone;
	wire       mbSel    = address[9] == 1'b1;
	wire [2:0] mbIdx    = address[7:5];
	wire [2:0] mbReg    = address[4:2];
	wire [9:0] glbAddr  = {address[9:2], 2'b00};
	wire       srRead   = rdEn && !mbSel && glbAddr == cmt_pkg::SR_OFS;
	wire       tcrWrite = wrEn && !mbSel && glbAddr == cmt_pkg::TCR_OFS;
	wire       mcrWrite = wrEn && mbSel && mbReg == cmt_pkg::MB_MCR;

	wire       ctrlEn   = mrQ[cmt_pkg::MR_EN];
	wire       ttMode   = mrQ[cmt_pkg::MR_TTM];

	// ************************************************************
	// receive and producer matching
	// ************************************************************
	logic [NMB-1:0] hitVec, availVec, prodVec, ackVec, reqVec, trigVec, doneVec;
	logic [2:0]     typeOf [NMB];
	logic [3:0]     prioOf [NMB];
	for (genvar g = 0; g < NMB; g++) begin : gMb
		assign typeOf[g]   = mmrQ[g][cmt_pkg::MMR_TYPE_LO +: 3]; // [R1]
		assign prioOf[g]   = mmrQ[g][cmt_pkg::MMR_PRIO_LO +: 4];
		assign hitVec[g]   = idMatch(midQ[g], mamQ[g], rxId, rxExt); // [R12]
		assign availVec[g] = hitVec[g] && !rxRemote &&
			((typeOf[g] == cmt_pkg::OT_RX && !rdyQ[g]) || // [R7]
			typeOf[g] == cmt_pkg::OT_RXOVR ||
			(typeOf[g] == cmt_pkg::OT_CONS && waitAnsQ[g])); // [R8]
		assign prodVec[g]  = rxValid && rxRemote && hitVec[g] &&
			typeOf[g] == cmt_pkg::OT_PROD; // [R11]
		assign ackVec[g]   = mcrWrite && mbIdx == 3'(g) && writedata[cmt_pkg::MCR_ACK];
		assign reqVec[g]   = tcrWrite && !ttMode && writedata[g]; // [R8]
		assign trigVec[g]  = ttMode && ctrlEn && bitTick &&
			timQ == mmrQ[g][15:0] && typeOf[g] != cmt_pkg::OT_OFF; // [R21]
		assign doneVec[g]  = txDone && txStQ == cmt_pkg::TX_BUSY && txIdxQ == 3'(g);
	end

	wire       rxStore = rxValid && availVec != 8'h00;
	wire [2:0] rxWin   = lowestSet(availVec); // [R6]

	// ************************************************************
	// transmit arbitration: lower field value wins, then lower index
	// ************************************************************
	logic [2:0] bestIdx;
	logic       anyPend;
	always_comb begin
		bestIdx = 3'h0;
		anyPend = 1'b0;
		for (int k = 0; k < NMB; k++) begin
			if (pendQ[k] && (!anyPend || prioOf[k] < prioOf[bestIdx])) begin
				bestIdx = 3'(k); // [R10]
				anyPend = 1'b1;
			end
		end
	end

	assign rdyD     = (rdyQ & ~ackVec) |
		(rxStore ? (8'h01 << rxWin) : 8'h00);
	assign pendD    = (pendQ & ~doneVec) | reqVec | trigVec | prodVec; // [R11] [R21]
	assign waitAnsD = (waitAnsQ & ~(rxStore ? (8'h01 << rxWin) : 8'h00)) |
		(txRemote ? doneVec : 8'h00); // [R8]

	// ************************************************************
	// time management
	// ************************************************************
	wire lastRdy   = rdyQ[NMB-1];
	wire clrTimer  = (mrQ[cmt_pkg::MR_LPM] && sleepState) ||
		(ctrlEn && !enPrevQ) ||
		(ttMode && lastRdy && !lastRdyPrevQ) ||
		(tcrWrite && writedata[cmt_pkg::TCR_TCLR]); // [R14] [R15]
	wire atMax     = timQ == cmt_pkg::TIM_MAX;
	wire holding   = mrQ[cmt_pkg::MR_HOLD] && atMax;
	wire tickCnt   = ctrlEn && bitTick && !holding; // [R13]
	wire wrapEvt   = tickCnt && atMax && !clrTimer; // [R16]
	wire holdEvt   = ctrlEn && bitTick && mrQ[cmt_pkg::MR_HOLD] &&
		timQ == (cmt_pkg::TIM_MAX - 16'h0001) && !clrTimer; // [R18]
	wire stampEvt  = mrQ[cmt_pkg::MR_STAMP_AT_FRAME_END] ? eofPulse : sofPulse; // [R19]

	assign timD = clrTimer ? 16'h0000 : (tickCnt ? timQ + 16'h0001 : timQ);

	// ************************************************************
	// read data selection
	// ************************************************************
	wire [31:0] mbWord =
		mbReg == cmt_pkg::MB_MMR ? mmrQ[mbIdx] :
		mbReg == cmt_pkg::MB_MAM ? mamQ[mbIdx] :
		mbReg == cmt_pkg::MB_MID ? midQ[mbIdx] :
		mbReg == cmt_pkg::MB_FID ? fidQ[mbIdx] :
		mbReg == cmt_pkg::MB_MSR ? ({7'h00, pendQ[mbIdx], rdyQ[mbIdx], 23'h000000} |
			{28'h0000000, lenQ[mbIdx]}) :
		mbReg == cmt_pkg::MB_DL  ? dlQ[mbIdx] :
		mbReg == cmt_pkg::MB_DH  ? dhQ[mbIdx] : cmt_pkg::WORD_ZERO;
	wire [31:0] glbWord =
		glbAddr == cmt_pkg::MR_OFS  ? {27'h0000000, mrQ} :
		glbAddr == cmt_pkg::IMR_OFS ? {30'h00000000, imrQ} :
		glbAddr == cmt_pkg::SR_OFS  ? {29'h00000000, sleepState, stampQ, wrapQ} :
		glbAddr == cmt_pkg::TIM_OFS ? {16'h0000, timQ} : // [R15]
		glbAddr == cmt_pkg::STP_OFS ? {16'h0000, stpQ} : cmt_pkg::WORD_ZERO;
	wire [31:0] rdWord = mbSel ? (address[8] ? cmt_pkg::WORD_ZERO : mbWord) : glbWord;

	// ************************************************************
	// bus slave: one wait cycle per access
	// ************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			waitQ    <= 1'b1;
			readdata <= 32'h00000000;
		end else begin
			waitQ    <= ~(busReq & waitQ);
			readdata <= (busReq & waitQ & read) ? rdWord : readdata;
		end
	end
	assign waitrequest = waitQ;

	// ************************************************************
	// global control and status
	// ************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mrQ          <= 5'h00;
			imrQ         <= 2'h0;
			wrapQ        <= 1'b0;
			stampQ       <= 1'b0;
			timQ         <= 16'h0000; // [R14]
			stpQ         <= 16'h0000;
			enPrevQ      <= 1'b0;
			lastRdyPrevQ <= 1'b0;
			irq          <= 1'b0;
		end else begin
			if (wrEn && !mbSel && glbAddr == cmt_pkg::MR_OFS) mrQ <= writedata[4:0];
			if (wrEn && !mbSel && glbAddr == cmt_pkg::IMR_OFS) imrQ <= writedata[1:0];
			// later set survives the read
			wrapQ        <= (wrapQ & ~(srRead & readdata[cmt_pkg::SR_WRAP])) |
				wrapEvt | holdEvt; // [R16] [R18]
			stampQ       <= (stampQ & ~(srRead & readdata[cmt_pkg::SR_STAMP])) |
				stampEvt; // [R20]
			timQ         <= timD;
			if (stampEvt) stpQ <= timQ; // [R19]
			enPrevQ      <= ctrlEn;
			lastRdyPrevQ <= lastRdy;
			irq          <= (wrapQ & imrQ[0]) | (stampQ & imrQ[1]); // [R17] [R20]
		end
	end

	// ************************************************************
	// mailbox storage and flags
	// ************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int k = 0; k < NMB; k++) begin
				mmrQ[k] <= 32'h00000000;
				mamQ[k] <= 32'h00000000;
				midQ[k] <= 32'h00000000;
				fidQ[k] <= 32'h00000000;
				dlQ[k]  <= 32'h00000000;
				dhQ[k]  <= 32'h00000000;
				lenQ[k] <= 4'h0;
			end
			rdyQ     <= '0;
			pendQ    <= '0;
			waitAnsQ <= '0;
		end else begin
			if (wrEn && mbSel && !address[8]) begin
				case (mbReg)
					cmt_pkg::MB_MMR: mmrQ[mbIdx] <= writedata;
					cmt_pkg::MB_MAM: mamQ[mbIdx] <= writedata;
					cmt_pkg::MB_MID: midQ[mbIdx] <= writedata; // [R12]
					cmt_pkg::MB_DL:  dlQ[mbIdx]  <= writedata;
					cmt_pkg::MB_DH:  dhQ[mbIdx]  <= writedata;
					cmt_pkg::MB_MCR: lenQ[mbIdx] <= writedata[19:16];
					default: ;
				endcase
			end
			if (rxStore) begin
				midQ[rxWin] <= {midQ[rxWin][31:30], rxExt, rxId}; // [R3]
				fidQ[rxWin] <= packFamily(rxId, mamQ[rxWin][28:0], rxExt); // [R4]
				dlQ[rxWin]  <= rxData[31:0]; // [R6] [R22]
				dhQ[rxWin]  <= rxData[63:32];
				lenQ[rxWin] <= rxLen;
			end
			rdyQ     <= rdyD; // [R7]
			pendQ    <= pendD;
			waitAnsQ <= waitAnsD;
		end
	end

	// ************************************************************
	// transmit request to the frame engine
	// ************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			txStQ    <= cmt_pkg::TX_IDLE;
			txIdxQ   <= 3'h0;
			txReq    <= 1'b0;
			txExt    <= 1'b0;
			txRemote <= 1'b0;
			txId     <= 29'h00000000;
			txLen    <= 4'h0;
			txData   <= 64'h0000000000000000;
		end else begin
			case (txStQ)
				cmt_pkg::TX_IDLE: begin
					if (anyPend) begin
						txStQ    <= cmt_pkg::TX_BUSY;
						txIdxQ   <= bestIdx; // [R10]
						txReq    <= 1'b1;
						txExt    <= midQ[bestIdx][cmt_pkg::MID_IDE];
						txRemote <= typeOf[bestIdx] == cmt_pkg::OT_CONS; // [R8] [R23]
						txId     <= midQ[bestIdx][28:0];
						txLen    <= lenQ[bestIdx];
						txData   <= {dhQ[bestIdx], dlQ[bestIdx]}; // [R11]
					end
				end
				cmt_pkg::TX_BUSY: begin
					if (txDone) begin
						txStQ <= cmt_pkg::TX_IDLE;
						txReq <= 1'b0;
					end
				end
				default: txStQ <= cmt_pkg::TX_IDLE;
			endcase
		end
	end
endmodule

// ---- tb/cmt_mailbox_unit_asserts.sv ----
// Purpose: port checker for the mailbox and timer unit
// Assumes: one clock domain, rst asynchronous and active high
// Notes:   attached by the bind after the module
`timescale 1ns/10ps
module cmt_mailbox_unit_asserts (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        bitTick,
	input wire logic        sofPulse,
	input wire logic        eofPulse,
	input wire logic        txReq,
	input wire logic        txRemote,
	input wire logic [28:0] txId,
	input wire logic [63:0] txData,
	input wire logic        txDone,
	input wire logic        irq
);
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire req    = read | write;
	wire wrDone = write & ~waitrequest;
	wire rdDone = read & ~waitrequest;
	AST_WAIT_ANSWER: assert property (req && waitrequest |=> !waitrequest)
		else $error("access not answered after one cycle");
	AST_WAIT_ONE: assert property (!waitrequest |=> waitrequest)
		else $error("answer held longer than one cycle");
	AST_WAIT_IDLE: assert property (!req && waitrequest |=> waitrequest)
		else $error("answer without a request");
	AST_RDATA_HOLD: assert property (!(read && waitrequest) |=> $stable(readdata))
		else $error("read data moved without a read");
	AST_TX_HOLD: assert property (txReq && !txDone |=>
		txReq && $stable(txId) && $stable(txData) && $stable(txRemote))
		else $error("pending frame changed before done");
	AST_TX_DROP: assert property (txReq && txDone |=> !txReq)
		else $error("request kept after done");
	AST_TX_FALL: assert property ($fell(txReq) |-> $past(txDone))
		else $error("request dropped without done");
	AST_IRQ_RISE: assert property ($rose(irq) |-> $past(bitTick, 2) || $past(sofPulse, 2)
		|| $past(eofPulse, 2) || $past(wrDone, 2))
		else $error("interrupt rose without a cause");
	AST_IRQ_FALL: assert property ($fell(irq) |-> $past(rdDone, 2) || $past(wrDone, 2))
		else $error("interrupt fell without an access");
endmodule
bind cmt_mailbox_unit cmt_mailbox_unit_asserts u_chk (.sys_clk, .rst, .read, .write,
	.readdata, .waitrequest, .bitTick, .sofPulse, .eofPulse, .txReq, .txRemote, .txId,
	.txData, .txDone, .irq);

// ---- tb/cmt_engine_model.sv ----
// Purpose: behavioural frame engine standing for the bus nodes
// Assumes: bit ticks follow tickOn, one per cycle
// Notes:   released id and data fields show the inverse of the last frame
`timescale 1ns/10ps
module cmt_engine_model (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        tickOn,
	input  wire logic        sleepReq,
	input  wire logic [7:0]  ansDelay,
	input  wire logic        txReq,
	input  wire logic        txRemote,
	input  wire logic [28:0] txId,
	input  wire logic [63:0] txData,
	output logic             bitTick,
	output logic             sleepState,
	output logic             sofPulse,
	output logic             eofPulse,
	output logic             rxValid,
	output logic             rxExt,
	output logic             rxRemote,
	output logic      [28:0] rxId,
	output logic      [3:0]  rxLen,
	output logic      [63:0] rxData,
	output logic             txDone,
	output logic      [7:0]  txCount,
	output logic             lastRemote,
	output logic      [28:0] lastId,
	output logic      [63:0] lastData
);
	logic       busyQ;
	logic [7:0] cntQ;
	assign bitTick    = tickOn;
	assign sleepState = sleepReq;
	initial begin
		{sofPulse, eofPulse, rxValid, rxExt, rxRemote} = 5'h00;
		rxId   = 29'h00000000;
		rxLen  = 4'h8;
		rxData = 64'h0000000000000000;
	end
	// one frame: start, fields for one cycle, end
	task automatic send(input logic e, input logic r, input logic [28:0] id,
		input logic [63:0] d);
		@(posedge sys_clk);
		sofPulse <= 1'b1;
		@(posedge sys_clk);
		sofPulse <= 1'b0;
		{rxValid, rxExt, rxRemote, rxId, rxData} <= {1'b1, e, r, id, d};
		@(posedge sys_clk);
		{rxValid, rxId, rxData} <= {1'b0, ~id, ~d};
		eofPulse <= 1'b1;
		@(posedge sys_clk);
		eofPulse <= 1'b0;
	endtask
	// slow answers leave time for other mailboxes to queue up
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			{busyQ, txDone, cntQ, txCount} <= 18'h00000;
		end else begin
			txDone <= 1'b0;
			if (!busyQ && txReq && !txDone) begin
				{busyQ, cntQ} <= {1'b1, ansDelay};
				{lastRemote, lastId, lastData} <= {txRemote, txId, txData};
			end else if (busyQ && cntQ != 8'h00) begin
				cntQ <= cntQ - 8'h01;
			end else if (busyQ) begin
				{txDone, busyQ} <= 2'b10;
				txCount <= txCount + 8'h01;
			end
		end
	end
endmodule

// ---- tb/test_can_mailbox_and_timer_unit.sv ----
// Purpose: register level test of the mailbox and timer unit
// Assumes: Avalon access answers on its own; engine model on far side
// Notes:   one timer wrap run costs about 65k cycles
`timescale 1ns/10ps
module test_can_mailbox_and_timer_unit;
	logic        sys_clk, rst, read, write, waitrequest, irq, tickOn, sleepReq;
	logic        bitTick, sofPulse, eofPulse, sleepState, rxValid, rxExt, rxRemote;
	logic        txReq, txRemote, txDone, lastRemote;
	logic [9:0]  address;
	logic [31:0] writedata, readdata;
	logic [28:0] rxId, txId, lastId;
	logic [3:0]  rxLen;
	logic [63:0] rxData, txData, lastData;
	logic [7:0]  ansDelay, txCount;
	int          failures, num_checks;
	localparam logic [31:0] MMRV [8] = '{32'h01000000, 32'h01000000, 32'h02000000,
		32'h01000000, 32'h03030000, 32'h03010000, 32'h05000000, 32'h04000000};
	localparam logic [31:0] MIDV [8] = '{32'h20ABCDE0, 32'h20ABCDE0, 32'h20ABCDE0,
		32'h168C0000, 32'h20444444, 32'h20555555, 32'h20666666, 32'h20777777};
	cmt_mailbox_unit u_dut (.sys_clk, .rst, .address, .read, .write, .writedata,
		.readdata, .waitrequest, .bitTick, .sofPulse, .eofPulse, .sleepState, .rxValid,
		.rxExt, .rxRemote, .rxId, .rxLen, .rxData, .txReq, .txExt(), .txRemote, .txId,
		.txLen(), .txData, .txDone, .irq);
	cmt_engine_model u_eng (.sys_clk, .rst, .tickOn, .sleepReq, .ansDelay, .txReq,
		.txRemote, .txId, .txData, .bitTick, .sleepState, .sofPulse, .eofPulse, .rxValid,
		.rxExt, .rxRemote, .rxId, .rxLen, .rxData, .txDone, .txCount, .lastRemote,
		.lastId, .lastData);
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// ****************************************
	// tasks
	// ****************************************
	task automatic report_and_stop();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// request held until the edge that sees waitrequest low
	task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge sys_clk);
		{write, read, address, writedata} <= {w, !w, a, d};
		do begin
			@(posedge sys_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		q = readdata;
		{write, read} <= 2'b00;
		if (n >= 50) begin
			failures++;
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
	endtask
	task automatic rdc(input string what, input logic [9:0] a, input logic [31:0] exp,
		input logic [31:0] m);
		logic [31:0] q;
		acc(1'b0, a, 32'h00000000, q);
		chk(what, exp, q & m);
	endtask
	function automatic logic [9:0] mb(input int n, input logic [2:0] r);
		return cmt_pkg::MB_BASE + 10'(n * 32) + {5'h00, r, 2'b00};
	endfunction
	task automatic tick(input int k);
		@(posedge sys_clk);
		tickOn <= 1'b1;
		repeat (k) @(posedge sys_clk);
		tickOn <= 1'b0;
	endtask
	task automatic wait_tx(input logic [7:0] k);
		int i;
		i = 0;
		while (txCount !== k && i < 300) begin
			@(posedge sys_clk);
			i++;
		end
		if (i >= 300) begin
			failures++;
			report_and_stop();
		end
	endtask
	// ****************************************
	// sequence
	// ****************************************
	initial begin
		{rst, read, write, tickOn, sleepReq} = 5'b10000;
		{address, writedata, ansDelay} = 50'h0;
		{failures, num_checks} = 64'h0;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		rdc("timer after reset", cmt_pkg::TIM_OFS, 32'h0, 32'hFFFFFFFF);
		rdc("unmapped", 10'h100, 32'h0, 32'hFFFFFFFF);
		wr(cmt_pkg::MR_OFS, 32'h00000001);
		wr(cmt_pkg::TCR_OFS, 32'h80000000);
		tick(5);
		rdc("timer count", cmt_pkg::TIM_OFS, 32'h5, 32'hFFFF);
		wr(cmt_pkg::MR_OFS, 32'h00000000);
		tick(3);
		rdc("timer stopped", cmt_pkg::TIM_OFS, 32'h5, 32'hFFFF);
		wr(cmt_pkg::MR_OFS, 32'h00000001);
		rdc("timer re-enable", cmt_pkg::TIM_OFS, 32'h0, 32'hFFFF);
		tick(4);
		sleepReq <= 1'b1;
		wr(cmt_pkg::MR_OFS, 32'h00000003);
		rdc("timer low power", cmt_pkg::TIM_OFS, 32'h0, 32'hFFFF);
		sleepReq <= 1'b0;
		wr(cmt_pkg::MR_OFS, 32'h00000001);
		for (int n = 0; n < 8; n++) begin
			wr(mb(n, cmt_pkg::MB_MMR), MMRV[n]);
			wr(mb(n, cmt_pkg::MB_MAM), n < 3 ? 32'h1FFFFFEC : n == 3 ? 32'h1FFC0000 : 32'h1FFFFFFF);
			wr(mb(n, cmt_pkg::MB_MID), MIDV[n]);
			wr(mb(n, cmt_pkg::MB_DL), 32'hC0DE0000 | 32'(n));
			wr(mb(n, cmt_pkg::MB_DH), 32'hBEEF0000 | 32'(n));
		end
		wr(cmt_pkg::IMR_OFS, 32'h00000002);
		wr(cmt_pkg::TCR_OFS, 32'h80000000);
		tick(6);
		u_eng.send(1'b1, 1'b0, 29'h0ABCDF2, 64'h1);
		repeat (2) @(posedge sys_clk);
		chk("stamp irq", 32'h1, {31'h0, irq});
		rdc("stamp", cmt_pkg::STP_OFS, 32'h6, 32'hFFFF);
		rdc("status stamp", cmt_pkg::SR_OFS, 32'h2, 32'h3);
		rdc("status cleared", cmt_pkg::SR_OFS, 32'h0, 32'h3);
		repeat (2) @(posedge sys_clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rdc("mid0", mb(0, cmt_pkg::MB_MID), 32'h20ABCDF2, 32'hFFFFFFFF);
		rdc("family0", mb(0, cmt_pkg::MB_FID), 32'h6, 32'hFFFFFFFF);
		rdc("ready0", mb(0, cmt_pkg::MB_MSR), 32'h00800000, 32'h00800000);
		rdc("ready1", mb(1, cmt_pkg::MB_MSR), 32'h0, 32'h00800000);
		u_eng.send(1'b1, 1'b0, 29'h0ABCDE1, 64'h2);
		rdc("data1", mb(1, cmt_pkg::MB_DL), 32'h2, 32'hFFFFFFFF);
		rdc("family1", mb(1, cmt_pkg::MB_FID), 32'h1, 32'hFFFFFFFF);
		rdc("data0 locked", mb(0, cmt_pkg::MB_DL), 32'h1, 32'hFFFFFFFF);
		u_eng.send(1'b1, 1'b0, 29'h0ABCDE0, 64'h3);
		u_eng.send(1'b1, 1'b0, 29'h0ABCDE0, 64'h4);
		rdc("overwrite", mb(2, cmt_pkg::MB_DL), 32'h4, 32'hFFFFFFFF);
		wr(mb(0, cmt_pkg::MB_MCR), 32'h00800000);
		rdc("ack0", mb(0, cmt_pkg::MB_MSR), 32'h0, 32'h00800000);
		u_eng.send(1'b1, 1'b0, 29'h0ABCDE0, 64'h5);
		rdc("data0 again", mb(0, cmt_pkg::MB_DL), 32'h5, 32'hFFFFFFFF);
		u_eng.send(1'b0, 1'b0, 29'h168C0000, 64'h6);
		rdc("standard", mb(3, cmt_pkg::MB_DL), 32'h6, 32'hFFFFFFFF);
		ansDelay <= 8'd20;
		wr(cmt_pkg::TCR_OFS, 32'h00000030);
		wait_tx(8'd1);
		chk("first sent", 32'h0555555, {3'h0, lastId});
		chk("first data", 32'hBEEF0005, lastData[63:32]);
		wait_tx(8'd2);
		chk("second sent", 32'h0444444, {3'h0, lastId});
		ansDelay <= 8'd0;
		u_eng.send(1'b1, 1'b1, 29'h0666666, 64'h0);
		wait_tx(8'd3);
		chk("producer", 32'hC0DE0006, lastData[31:0]);
		chk("producer kind", 32'h0, {31'h0, lastRemote});
		wr(cmt_pkg::TCR_OFS, 32'h00000080);
		wait_tx(8'd4);
		chk("consumer", 32'h1, {31'h0, lastRemote});
		u_eng.send(1'b1, 1'b0, 29'h0777777, 64'h77);
		u_eng.send(1'b1, 1'b0, 29'h0777777, 64'h88);
		rdc("consumer data", mb(7, cmt_pkg::MB_DL), 32'h77, 32'hFFFFFFFF);
		wr(cmt_pkg::MR_OFS, 32'h00000005);
		wr(cmt_pkg::IMR_OFS, 32'h00000001);
		rdc("status flush", cmt_pkg::SR_OFS, 32'h0, 32'h1);
		wr(cmt_pkg::TCR_OFS, 32'h80000000);
		tick(65535);
		tick(3);
		rdc("held", cmt_pkg::TIM_OFS, 32'hFFFF, 32'hFFFF);
		chk("wrap irq", 32'h1, {31'h0, irq});
		rdc("wrap flag", cmt_pkg::SR_OFS, 32'h1, 32'h1);
		rdc("wrap cleared", cmt_pkg::SR_OFS, 32'h0, 32'h1);
		wr(cmt_pkg::TCR_OFS, 32'h80000000);
		tick(2);
		rdc("restart", cmt_pkg::TIM_OFS, 32'h2, 32'hFFFF);
		chk("irq off", 32'h0, {31'h0, irq});
		wr(cmt_pkg::MR_OFS, 32'h00000011);
		wr(cmt_pkg::TCR_OFS, 32'h80000000);
		tick(1);
		wait_tx(8'd12);
		report_and_stop();
	end
endmodule
